// ### pll_cfg_defines.svh
// Register offsets, field positions and reset values of the serializer PLL configuration block
// Included by the design and the testbench; definitions only
`ifndef PLL_CFG_DEFINES_SVH
`define PLL_CFG_DEFINES_SVH

// Printed offsets are register indices; byte address is four times the index
`define IDX_FEEDBACK_DIVIDER 12'h0508
`define IDX_DIVIDER_OVERRIDE_CTRL 12'h050A
`define IDX_RECEIVE_DIVIDE_RATE 12'h050B
`define IDX_VCO_TRIM 12'h050C
`define IDX_REFERENCE_CONDITIONING 12'h050D
`define IDX_INDIRECT_READ_ENABLE 12'h050E
`define IDX_INDIRECT_WRITE_STROBE 12'h050F
`define IDX_CLOCK_DISTRIBUTION_ENABLE 12'h0510
`define IDX_POLYPHASE_DEBUG_TRIM 12'h0511
`define IDX_VCO_BAND_LOW 12'h0512
`define IDX_VCO_BAND_HIGH 12'h0513
`define IDX_BIAS_STARTUP_CTRL 12'h0514
`define IDX_BIAS_STARTUP_STATUS_A 12'h0515
`define IDX_BIAS_STARTUP_STATUS_B 12'h0516
`define IDX_TEMPERATURE_TRIGGER 12'h0517
`define IDX_LOCK_TIMER_CTRL_LOW 12'h051E
`define IDX_LOCK_TIMER_CTRL_HIGH 12'h051F
`define IDX_INDIRECT_WR_DATA 12'h0521
`define IDX_INDIRECT_RD_DATA 12'h0522

// Field positions of the override register
`define OVD_FEEDBACK_BIT 0
`define OVD_OUTPUT_DIV_BIT 1
`define OVD_REF_DIV_BIT 2
`define OVD_RX_RATE_BIT 3

// Reset values, minimum feedback field and feedback multiplier
`define RST_FEEDBACK_DIV 8'h05
`define RST_OVERRIDE 4'h7
`define RST_RX_RATE 4'h8
`define RST_REF_COND 2'h1
`define RST_POLYPHASE 8'h2F
`define MIN_FEEDBACK_DIV 8'h05
`define FEEDBACK_MULT 11'h008

`endif

// ### pll_cfg_pkg.sv
// Types of the serializer PLL configuration block
// Constants live in pll_cfg_defines.svh
package pll_cfg_pkg;

    // APB request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [13:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // APB answer
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Controls driven toward the PLL analog and sequencer
    typedef struct packed {
        logic [10:0] feedback_ratio;
        logic feedback_div_override;
        logic output_div_override;
        logic ref_div_override;
        logic rx_rate_override;
        logic [3:0] rx_rate_value;
        logic [5:0] vco_trim;
        logic ref_div_three_en;
        logic ref_coupling_sel;
        logic clk_dist_en_a;
        logic clk_dist_en_b;
        logic [7:0] polyphase_trim;
        logic [7:0] bias_startup;
        logic temp_meas_trigger;
        logic lock_source_sel;
        logic [9:0] lock_timer_count;
        logic indirect_rd_en;
        logic indirect_wr_strobe;
        logic [7:0] indirect_wr_data;
    } pll_ctrl_t;

    // Status returned from the PLL
    typedef struct packed {
        logic [10:0] vco_band_word;
        logic bias_status_a;
        logic bias_status_b;
        logic [7:0] indirect_rd_data;
    } pll_stat_t;

    // Whole state of the block
    typedef struct packed {
        pll_ctrl_t ctrl;
        logic [7:0] feedback_div_value;
        logic temp_level;
        logic [7:0] rd_data_held;
        apb_rsp_t rsp;
    } cfg_state_t;

endpackage

// ### pll_cfg_regs.sv
// Serializer PLL configuration and readback registers behind an APB slave
// Assumes pclk at 50 MHz, inputs synchronous to pclk, status inputs stable in pclk domain
// How it works
// - The PLL feedback ratio is eight times the 8-bit feedback field, which resets to five.
// - The feedback override bit, reset one, makes the PLL use the field instead of octave cal.
// - The 4-bit receive rate field, reset eight, applies while its override bit (reset zero) is one.
// - The divide-by-three bit, reset zero, adds a divide by three on the reference clock.
// - The coupling bit, reset one, selects DC coupling when one and AC coupling when zero.
// - The read-enable bit, reset zero, starts indirect reads of the PLL internal registers.
// - The write-strobe bit, reset zero, commits write data into the PLL internal registers.
// - Two distribution bits, both reset zero, each enable serializer clocks when one.
// - The polyphase trim byte resets to 0x2F with override fields at bits 6:5, 4, 3:1 and 0.
// - The 11-bit VCO band word reads back as low eight bits then upper three bits.
// - Only a zero-to-one write of the temperature bit starts one measurement.
// - The lock select bit and a 10-bit lock timer count split as 3:0 and 9:4.
// - An 8-bit write-data register feeds the indirect write transfer.
// - An 8-bit read-only register returns the data fetched by the indirect read.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "pll_cfg_defines.svh"

module pll_cfg_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire pll_cfg_pkg::pll_stat_t pll_stat,
    output pll_cfg_pkg::pll_ctrl_t pll_ctrl
);
    import pll_cfg_pkg::*;

    cfg_state_t state_ff;
    cfg_state_t nxt_state;
    logic [11:0] reg_index;
    logic addr_ok;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic hit;

    assign reg_index = paddr[13:2];
    assign addr_ok = (paddr[1:0] == 2'b00);
    assign wbyte = pwdata[7:0];

    // Read mux, reserved bits return zero
    always_comb begin
        hit = 1'b1;
        rbyte = 8'h00;
        case (reg_index)
            `IDX_FEEDBACK_DIVIDER: begin
                rbyte = state_ff.feedback_div_value;
            end
            `IDX_DIVIDER_OVERRIDE_CTRL: begin
                rbyte = {4'h0, state_ff.ctrl.rx_rate_override, state_ff.ctrl.ref_div_override,
                         state_ff.ctrl.output_div_override,
                         state_ff.ctrl.feedback_div_override};
            end
            `IDX_RECEIVE_DIVIDE_RATE: begin
                rbyte = {4'h0, state_ff.ctrl.rx_rate_value};
            end
            `IDX_VCO_TRIM: begin
                rbyte = {2'b00, state_ff.ctrl.vco_trim};
            end
            `IDX_REFERENCE_CONDITIONING: begin
                rbyte = {6'h00, state_ff.ctrl.ref_div_three_en, state_ff.ctrl.ref_coupling_sel};
            end
            `IDX_INDIRECT_READ_ENABLE: begin
                rbyte = {7'h00, state_ff.ctrl.indirect_rd_en};
            end
            `IDX_INDIRECT_WRITE_STROBE: begin
                rbyte = {7'h00, state_ff.ctrl.indirect_wr_strobe};
            end
            `IDX_CLOCK_DISTRIBUTION_ENABLE: begin
                rbyte = {6'h00, state_ff.ctrl.clk_dist_en_a, state_ff.ctrl.clk_dist_en_b};
            end
            `IDX_POLYPHASE_DEBUG_TRIM: begin
                rbyte = state_ff.ctrl.polyphase_trim;
            end
            `IDX_VCO_BAND_LOW: begin
                rbyte = pll_stat.vco_band_word[7:0];
            end
            `IDX_VCO_BAND_HIGH: begin
                rbyte = {5'h00, pll_stat.vco_band_word[10:8]};
            end
            `IDX_BIAS_STARTUP_CTRL: begin
                rbyte = state_ff.ctrl.bias_startup;
            end
            `IDX_BIAS_STARTUP_STATUS_A: begin
                rbyte = {7'h00, pll_stat.bias_status_a};
            end
            `IDX_BIAS_STARTUP_STATUS_B: begin
                rbyte = {7'h00, pll_stat.bias_status_b};
            end
            `IDX_TEMPERATURE_TRIGGER: begin
                rbyte = {7'h00, state_ff.temp_level};
            end
            `IDX_LOCK_TIMER_CTRL_LOW: begin
                rbyte = {state_ff.ctrl.lock_timer_count[3:0], 3'b000,
                         state_ff.ctrl.lock_source_sel};
            end
            `IDX_LOCK_TIMER_CTRL_HIGH: begin
                rbyte = {2'b00, state_ff.ctrl.lock_timer_count[9:4]};
            end
            `IDX_INDIRECT_WR_DATA: begin
                rbyte = state_ff.ctrl.indirect_wr_data;
            end
            `IDX_INDIRECT_RD_DATA: begin
                rbyte = state_ff.rd_data_held;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (!addr_ok) begin
            hit = 1'b0;
        end
    end

    // Access phase takes one cycle; pready is registered in the setup cycle
    assign wr_en = psel && penable && state_ff.rsp.pready && pwrite && hit && pstrb[0];
    assign rd_en = psel && !penable && !pwrite;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.ctrl.temp_meas_trigger = 1'b0;
        // Indirect read data captured while a read is enabled
        if (state_ff.ctrl.indirect_rd_en) begin
            nxt_state.rd_data_held = pll_stat.indirect_rd_data;
        end
        nxt_state.rsp.pready = psel && !penable;
        nxt_state.rsp.pslverr = psel && !penable && !hit;
        nxt_state.rsp.prdata = (rd_en && hit) ? {24'h00_0000, rbyte} : 32'h0000_0000;
        if (wr_en) begin
            case (reg_index)
                `IDX_FEEDBACK_DIVIDER: begin
                    nxt_state.feedback_div_value = wbyte;
                end
                `IDX_DIVIDER_OVERRIDE_CTRL: begin
                    nxt_state.ctrl.feedback_div_override = wbyte[`OVD_FEEDBACK_BIT];
                    nxt_state.ctrl.output_div_override = wbyte[`OVD_OUTPUT_DIV_BIT];
                    nxt_state.ctrl.ref_div_override = wbyte[`OVD_REF_DIV_BIT];
                    nxt_state.ctrl.rx_rate_override = wbyte[`OVD_RX_RATE_BIT];
                end
                `IDX_RECEIVE_DIVIDE_RATE: begin
                    nxt_state.ctrl.rx_rate_value = wbyte[3:0];
                end
                `IDX_VCO_TRIM: begin
                    nxt_state.ctrl.vco_trim = wbyte[5:0];
                end
                `IDX_REFERENCE_CONDITIONING: begin
                    nxt_state.ctrl.ref_div_three_en = wbyte[1];
                    nxt_state.ctrl.ref_coupling_sel = wbyte[0];
                end
                `IDX_INDIRECT_READ_ENABLE: begin
                    nxt_state.ctrl.indirect_rd_en = wbyte[0];
                end
                `IDX_INDIRECT_WRITE_STROBE: begin
                    nxt_state.ctrl.indirect_wr_strobe = wbyte[0];
                end
                `IDX_CLOCK_DISTRIBUTION_ENABLE: begin
                    nxt_state.ctrl.clk_dist_en_a = wbyte[1];
                    nxt_state.ctrl.clk_dist_en_b = wbyte[0];
                end
                `IDX_POLYPHASE_DEBUG_TRIM: begin
                    nxt_state.ctrl.polyphase_trim = wbyte;
                end
                `IDX_BIAS_STARTUP_CTRL: begin
                    nxt_state.ctrl.bias_startup = wbyte;
                end
                `IDX_TEMPERATURE_TRIGGER: begin
                    nxt_state.temp_level = wbyte[0];
                    // One pulse only on a rising write
                    nxt_state.ctrl.temp_meas_trigger = wbyte[0] && !state_ff.temp_level;
                end
                `IDX_LOCK_TIMER_CTRL_LOW: begin
                    nxt_state.ctrl.lock_timer_count[3:0] = wbyte[7:4];
                    nxt_state.ctrl.lock_source_sel = wbyte[0];
                end
                `IDX_LOCK_TIMER_CTRL_HIGH: begin
                    nxt_state.ctrl.lock_timer_count[9:4] = wbyte[5:0];
                end
                `IDX_INDIRECT_WR_DATA: begin
                    nxt_state.ctrl.indirect_wr_data = wbyte;
                end
                default: begin
                    nxt_state.ctrl = nxt_state.ctrl; // Read-only or unmapped: writes ignored
                end
            endcase
        end
        // Feedback ratio N = 8 * B
        nxt_state.ctrl.feedback_ratio = `FEEDBACK_MULT * {3'b000, nxt_state.feedback_div_value};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Every field named so the reset image reads in one place
            state_ff.ctrl.feedback_ratio <= 11'h028;
            state_ff.ctrl.feedback_div_override <= 1'(`RST_OVERRIDE >> `OVD_FEEDBACK_BIT);
            state_ff.ctrl.output_div_override <= 1'(`RST_OVERRIDE >> `OVD_OUTPUT_DIV_BIT);
            state_ff.ctrl.ref_div_override <= 1'(`RST_OVERRIDE >> `OVD_REF_DIV_BIT);
            state_ff.ctrl.rx_rate_override <= 1'(`RST_OVERRIDE >> `OVD_RX_RATE_BIT);
            state_ff.ctrl.rx_rate_value <= `RST_RX_RATE;
            state_ff.ctrl.vco_trim <= 6'h00;
            state_ff.ctrl.ref_div_three_en <= 1'b0;
            state_ff.ctrl.ref_coupling_sel <= 1'b1;
            state_ff.ctrl.clk_dist_en_a <= 1'b0;
            state_ff.ctrl.clk_dist_en_b <= 1'b0;
            state_ff.ctrl.polyphase_trim <= `RST_POLYPHASE;
            state_ff.ctrl.bias_startup <= 8'h00;
            state_ff.ctrl.temp_meas_trigger <= 1'b0;
            state_ff.ctrl.lock_source_sel <= 1'b0;
            state_ff.ctrl.lock_timer_count <= 10'h000;
            state_ff.ctrl.indirect_rd_en <= 1'b0;
            state_ff.ctrl.indirect_wr_strobe <= 1'b0;
            state_ff.ctrl.indirect_wr_data <= 8'h00;
            state_ff.feedback_div_value <= `RST_FEEDBACK_DIV;
            state_ff.temp_level <= 1'b0;
            state_ff.rd_data_held <= 8'h00;
            state_ff.rsp.pready <= 1'b0;
            state_ff.rsp.pslverr <= 1'b0;
            state_ff.rsp.prdata <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pready = state_ff.rsp.pready;
    assign pslverr = state_ff.rsp.pslverr;
    assign prdata = state_ff.rsp.prdata;
    assign pll_ctrl = state_ff.ctrl;

endmodule // pll_cfg_regs

// ### pll_cfg_regs_asserts.sv
// Concurrent checks on the ports of the PLL configuration register block
// Bound to pll_cfg_regs from the testbench; one clock, async active-low reset
`timescale 1ns/10ps
module pll_cfg_regs_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire pll_cfg_pkg::pll_stat_t pll_stat,
    input wire pll_cfg_pkg::pll_ctrl_t pll_ctrl
);
    import pll_cfg_pkg::*;
    logic acc;
    logic wr_ok;
    logic lvl_ff;
    assign acc = psel && penable && pready;
    assign wr_ok = acc && pwrite && pstrb[0] && !pslverr;
    // Stored temperature level as software last wrote it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lvl_ff <= 1'b0;
        else if (wr_ok && paddr == 14'h145C) lvl_ff <= pwdata[0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ratio_eight_b: assert property (
        wr_ok && paddr == 14'h1420 |=> pll_ctrl.feedback_ratio == {$past(pwdata[7:0]), 3'b000})
        else $error("feedback ratio not eight times field");
    a_reset_values: assert property (
        !$past(presetn) |-> pll_ctrl.feedback_ratio == 11'h028 && pll_ctrl.feedback_div_override
        && !pll_ctrl.rx_rate_override && pll_ctrl.rx_rate_value == 4'h8 && pll_ctrl.ref_coupling_sel
        && !pll_ctrl.ref_div_three_en && !pll_ctrl.clk_dist_en_a && !pll_ctrl.clk_dist_en_b
        && pll_ctrl.polyphase_trim == 8'h2F)
        else $error("control outputs wrong after reset");
    a_temp_edge_only: assert property (
        wr_ok && paddr == 14'h145C |=> pll_ctrl.temp_meas_trigger == ($past(pwdata[0]) && !$past(lvl_ff)))
        else $error("temperature trigger not on rising write");
    a_band_low_read: assert property (
        acc && !pwrite && paddr == 14'h1448 |-> prdata == {24'h0, $past(pll_stat.vco_band_word[7:0])})
        else $error("band low byte wrong");
    a_band_high_read: assert property (
        acc && !pwrite && paddr == 14'h144C |-> prdata == {29'h0, $past(pll_stat.vco_band_word[10:8])})
        else $error("band high bits wrong");
    a_misaligned_err: assert property (
        acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0)
        else $error("misaligned access not refused");
    a_strobe_written: assert property (
        wr_ok && paddr == 14'h143C |=> pll_ctrl.indirect_wr_strobe == $past(pwdata[0]))
        else $error("write strobe not as written");
    a_wr_data_reg: assert property (
        wr_ok && paddr == 14'h1484 |=> pll_ctrl.indirect_wr_data == $past(pwdata[7:0]))
        else $error("indirect write data not as written");
    a_lock_low_split: assert property (
        wr_ok && paddr == 14'h1478 |=> pll_ctrl.lock_timer_count[3:0] == $past(pwdata[7:4])
        && pll_ctrl.lock_source_sel == $past(pwdata[0]))
        else $error("lock control low split wrong");
    c_temp_write: cover property (wr_ok && paddr == 14'h145C);
    c_refused: cover property (acc && pslverr);
    c_trigger: cover property (pll_ctrl.temp_meas_trigger);
endmodule // pll_cfg_regs_asserts

// ### test_pll_cfg_regs.sv
// Self-checking random bench for the serializer PLL configuration registers
// Assumes the package, the defines header and the design compile before it
`timescale 1ns/10ps
`include "pll_cfg_defines.svh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module test_pll_cfg_regs;
    import pll_cfg_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, pulse;
    logic [31:0] prdata;
    pll_stat_t pll_stat = '0;
    pll_ctrl_t pll_ctrl;
    logic [7:0] mdl [12'h508:12'h522];
    logic [7:0] hold;
    logic [11:0] tbl [22] = '{12'h508, 12'h50A, 12'h50B, 12'h50C, 12'h50D, 12'h50E, 12'h50F,
        12'h510, 12'h511, 12'h512, 12'h513, 12'h514, 12'h515, 12'h516, 12'h517, 12'h51E,
        12'h51F, 12'h521, 12'h522, 12'h509, 12'h520, 12'h7FF};
    logic [7:0] tv [4] = '{8'h01, 8'h01, 8'h00, 8'h01};
    int bad_count = 0, n_checks = 0, cyc = 0, seed = 32'ha9eb;
    pll_cfg_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .pll_stat(pll_stat), .pll_ctrl(pll_ctrl));
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 10000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // Indirect read holder follows the PLL data while read enable is set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) hold <= 8'h00;
        else if (mdl[12'h50E][0]) hold <= pll_stat.indirect_rd_data;
    end
    function automatic logic [7:0] wmask(input logic [11:0] i);
        case (i)
            12'h508, 12'h511, 12'h514, 12'h521: return 8'hFF;
            12'h50A, 12'h50B: return 8'h0F;
            12'h50C, 12'h51F: return 8'h3F;
            12'h50D, 12'h510: return 8'h03;
            12'h50E, 12'h50F, 12'h517: return 8'h01;
            12'h51E: return 8'hF1;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input logic [11:0] i);
        case (i)
            12'h512: return pll_stat.vco_band_word[7:0];
            12'h513: return {5'h0, pll_stat.vco_band_word[10:8]};
            12'h515: return {7'h0, pll_stat.bias_status_a};
            12'h516: return {7'h0, pll_stat.bias_status_b};
            12'h522: return hold;
            default: return mdl[i];
        endcase
    endfunction
    function automatic pll_ctrl_t exp_ctrl(input logic p);
        return {mdl[12'h508], 3'b000, mdl[12'h50A][0], mdl[12'h50A][1], mdl[12'h50A][2],
            mdl[12'h50A][3], mdl[12'h50B][3:0], mdl[12'h50C][5:0], mdl[12'h50D][1:0],
            mdl[12'h510][1:0], mdl[12'h511], mdl[12'h514], p, mdl[12'h51E][0],
            mdl[12'h51F][5:0], mdl[12'h51E][7:4], mdl[12'h50E][0], mdl[12'h50F][0], mdl[12'h521]};
    endfunction
    // One APB transfer with checks of the answer and of the control outputs
    task automatic op(input logic w, input logic [11:0] i, input logic [7:0] d,
            input logic [3:0] s, input logic [1:0] lo);
        int k;
        logic good;
        good = (wmask(i) != 8'h00 || i inside {12'h512, 12'h513, 12'h515, 12'h516, 12'h522})
            && lo == 2'b00;
        pulse = w && s[0] && good && i == 12'h517 && d[0] && !mdl[12'h517][0];
        @(posedge pclk);
        {pll_stat.vco_band_word, pll_stat.bias_status_a, pll_stat.bias_status_b} <= 13'($random(seed));
        if (!mdl[12'h50E][0]) pll_stat.indirect_rd_data <= 8'($random(seed));
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, lo};
        pwdata <= ({$random(seed)} & 32'hFFFF_FF00) | {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) bad_count++;
        `CHK("pslverr", !good, pslverr)
        `CHK("prdata", ((w || !good) ? 32'h0 : {24'h0, exp_rd(i)}), prdata)
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && s[0] && good) mdl[i] = d & wmask(i);
        @(negedge pclk);
        `CHK("pll_ctrl", exp_ctrl(pulse), pll_ctrl)
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        mdl = '{default: 8'h00};
        mdl[12'h508] = 8'h05;
        mdl[12'h50A] = 8'h07;
        mdl[12'h50B] = 8'h08;
        mdl[12'h50D] = 8'h01;
        mdl[12'h511] = 8'h2F;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int n = 0; n < 19; n++) op(1'b0, tbl[n], 8'h00, 4'h0, 2'b00);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [11:0] i;
        logic [7:0] d;
        logic [31:0] r;
        do_reset();
        op(1'b1, 12'h508, 8'hFF, 4'hF, 2'b00);
        op(1'b1, 12'h508, 8'h33, 4'hF, 2'b01);
        op(1'b1, 12'h512, 8'hFF, 4'hF, 2'b00);
        op(1'b1, 12'h50B, 8'h03, 4'hE, 2'b00);
        foreach (tv[n]) op(1'b1, 12'h517, tv[n], 4'h1, 2'b00);
        op(1'b1, 12'h50E, 8'h01, 4'h1, 2'b00);
        op(1'b0, 12'h522, 8'h00, 4'h0, 2'b00);
        op(1'b1, 12'h50E, 8'h00, 4'h1, 2'b00);
        op(1'b0, 12'h522, 8'h00, 4'h0, 2'b00);
        repeat (400) begin
            i = tbl[{$random(seed)} % 22];
            d = 8'($random(seed));
            if (i == 12'h508 && d < 8'h05) d = 8'h05;
            r = $random(seed);
            op(r[0], i, d, {3'b000, r[1] | r[2]}, (r[5:3] == 3'b000) ? r[7:6] : 2'b00);
        end
        do_reset();
        report_and_stop();
    end
endmodule // test_pll_cfg_regs
bind pll_cfg_regs pll_cfg_regs_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .pll_stat(pll_stat),
    .pll_ctrl(pll_ctrl));
